// ### logic/uart_sir_fifo_irq.sv
// How it works
// [RQ1] normal ir mode: zero bit sends high pulse 3/16 bit long, one stays low
// [RQ2] low-power ir mode: pulse is three low-power reference periods, chosen by control bit
// [RQ3] ir encoder takes its input from the transmit serial bit
// [RQ4] ir decoder turns a low pulse into a zero for the receiver
// [RQ5] software keeps 10 ms between transmit and receive; hardware adds nothing
// [RQ6] ir link is half-duplex; software finishes transmit before receiving
// [RQ7] ir enable puts encoded signals on the serial pins
// [RQ8] 16-entry tx and rx queues behind one data register; 12-bit reads, 8-bit writes
// [RQ9] after reset queues are one deep; queue_enable gives full depth
// [RQ10] flag register shows queue empty/full; rx status register shows overrun
// [RQ11] per-queue trigger level 1/8..7/8, both reset to one half
// [RQ12] all seven events ored onto one interrupt request
// [RQ13] event reaches request only if mask bit is one
// [RQ14] raw status shows every event regardless of mask
// [RQ15] writing one to clear register clears event; zero does nothing
// [RQ16] queued rx irq sets at level, clears below level or on clear
// [RQ17] single rx irq sets on fill, clears on read or on clear
// [RQ18] queued tx irq sets at level, clears above level or on clear
// [RQ19] single tx irq sets when empty, clears on write or on clear
// [RQ20] loopback enable feeds transmit output back to receive input
// [RQ21] ir encoder and decoder set by control register bits
// [RQ22] 16x oversample tick times transmit bits and samples receive bits
// [RQ23] receive timeout after 32 idle bit periods with data queued
// [RQ24] masked status is raw status and mask
`default_nettype none
module uart_sir_fifo_irq #(
    parameter int DEPTH = 16,
    parameter int TIMEOUT_BITS = 32
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [uart_pkg::ADDR_W-1:0] addr,
    input wire logic [uart_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [uart_pkg::DATA_W-1:0] rd_data,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic irq
);
    import uart_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);
    localparam logic [5:0] RT_LAST = 6'(TIMEOUT_BITS - 1);

    ////////////////////////////////////////////////////////////////////////
    // registers and decode
    logic [15:0] ibrd_q;
    logic [7:0] ilpr_q;
    logic [7:0] lcrh_q;
    logic [CTL_W-1:0] ctl_q;
    logic [5:0] ifls_q;
    logic [IRQ_W-1:0] im_q;
    logic [IRQ_W-1:0] ris_q;
    logic [IRQ_W-1:0] ris_d;
    logic [3:0] rsr_q;
    logic [3:0] rsr_d;
    logic [DATA_W-1:0] rd_word;

    wire wr_dr = wr_en && (addr == OFF_DATA);
    wire rd_dr = rd_en && (addr == OFF_DATA);
    wire wr_rsr = wr_en && (addr == OFF_RSR);
    wire wr_icr = wr_en && (addr == OFF_ICR);
    wire queue_enable = lcrh_q[LCRH_FEN];
    wire sir_en = ctl_q[CTL_SIR]; // see [RQ21]
    wire sir_lp = ctl_q[CTL_SIRLP];
    wire loopback_enable = ctl_q[CTL_LBE];
    wire tx_go = ctl_q[CTL_EN] && ctl_q[CTL_TXE];
    wire rx_go = ctl_q[CTL_EN] && ctl_q[CTL_RXE];
    wire [CW-1:0] depth_eff = queue_enable ? DEPTH_C : ONE_C; // see [RQ9]
    wire [IRQ_W-1:0] clr = wr_icr ? wr_data[IRQ_W-1:0] : '0; // see [RQ15]

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ibrd_q <= '0;
            ilpr_q <= '0;
            lcrh_q <= '0;
            ctl_q <= CTL_RST;
            ifls_q <= IFLS_RST; // see [RQ11]
            im_q <= '0;
        end else if (wr_en) begin
            if (addr == OFF_IBRD) ibrd_q <= wr_data[15:0];
            if (addr == OFF_ILPR) ilpr_q <= wr_data[7:0];
            if (addr == OFF_LCRH) lcrh_q <= wr_data[7:0];
            if (addr == OFF_CTL) ctl_q <= wr_data[CTL_W-1:0];
            if (addr == OFF_IFLS) ifls_q <= wr_data[5:0];
            if (addr == OFF_IM) im_q <= wr_data[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // oversample and low-power reference ticks
    logic [15:0] b16_cnt_q;
    logic [7:0] lp_cnt_q;
    // integer divisor only; zero divisor stops the tick
    wire oversample_ref_clk = (ibrd_q != '0) && (b16_cnt_q == '0); // see [RQ22]
    wire lowpower_ir_ref_clk = (ilpr_q != '0) && (lp_cnt_q == '0);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            b16_cnt_q <= '0;
            lp_cnt_q <= '0;
        end else begin
            b16_cnt_q <= (b16_cnt_q == '0 || b16_cnt_q >= ibrd_q) ? ibrd_q - 16'h1 : b16_cnt_q - 16'h1;
            lp_cnt_q <= (lp_cnt_q == '0 || lp_cnt_q >= ilpr_q) ? ilpr_q - 8'h1 : lp_cnt_q - 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // queues
    logic [7:0] tx_mem [DEPTH];
    rx_entry_s rx_mem [DEPTH];
    logic [PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [CW-1:0] tx_cnt_q, rx_cnt_q;
    logic tx_pop;
    logic rx_push;
    rx_entry_s rx_new;

    wire tx_full = tx_cnt_q >= depth_eff;
    wire rx_full = rx_cnt_q >= depth_eff;
    wire tx_empty = tx_cnt_q == '0;
    wire rx_empty = rx_cnt_q == '0;
    wire tx_push = wr_dr && !tx_full; // see [RQ8]
    wire rx_pop = rd_dr && !rx_empty;
    wire rx_ovr = rx_push && rx_full;
    wire rx_ins = rx_push && !rx_full;
    rx_entry_s rx_head;
    assign rx_head = rx_mem[rx_rp_q];

    always_ff @(posedge mclk) begin
        if (tx_push) tx_mem[tx_wp_q] <= wr_data[7:0];
        if (rx_ins) rx_mem[rx_wp_q] <= rx_new;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            if (tx_push) tx_wp_q <= tx_wp_q + PW'(1);
            if (tx_pop) tx_rp_q <= tx_rp_q + PW'(1);
            tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
            if (rx_ins) rx_wp_q <= rx_wp_q + PW'(1);
            if (rx_pop) rx_rp_q <= rx_rp_q + PW'(1);
            rx_cnt_q <= rx_cnt_q + CW'(rx_ins) - CW'(rx_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter and ir encoder
    tx_state_e tx_st_q;
    logic [3:0] tx_sub_q;
    logic [3:0] tx_idx_q;
    logic [7:0] tx_sh_q;
    logic tx_bit_q;
    logic [1:0] lp_left_q;

    wire tx_bit_end = (tx_st_q == TX_SHIFT) && oversample_ref_clk && (tx_sub_q == TICK_LAST);
    // start on a tick: full first pulse
    assign tx_pop = (tx_st_q == TX_IDLE) && tx_go && !tx_empty && oversample_ref_clk;
    wire zero_bit_start = (tx_st_q == TX_SHIFT) && oversample_ref_clk && (tx_sub_q == '0) && !tx_bit_q;
    wire norm_pulse = (tx_st_q == TX_SHIFT) && !tx_bit_q && (tx_sub_q < SIR_NORM_TICKS); // see [RQ1] [RQ3]
    wire lp_pulse = lp_left_q != '0; // see [RQ2]
    wire enc_out = sir_lp ? lp_pulse : norm_pulse;
    wire out_d = sir_en ? enc_out : tx_bit_q; // see [RQ7]

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_st_q <= TX_IDLE;
            tx_sub_q <= '0;
            tx_idx_q <= '0;
            tx_sh_q <= '0;
            tx_bit_q <= 1'b1;
        end else begin
            case (tx_st_q)
                TX_IDLE: begin
                    tx_bit_q <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_q <= tx_mem[tx_rp_q];
                        tx_bit_q <= 1'b0;
                        tx_sub_q <= '0;
                        tx_idx_q <= '0;
                        tx_st_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (oversample_ref_clk) tx_sub_q <= tx_sub_q + 4'h1;
                    if (tx_bit_end) begin
                        // ones shifted in behind the data form the stop bit
                        tx_bit_q <= tx_sh_q[0];
                        tx_sh_q <= {1'b1, tx_sh_q[7:1]};
                        tx_idx_q <= tx_idx_q + 4'h1;
                        if (tx_idx_q == DATA_LAST + 4'h2) tx_st_q <= TX_IDLE;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lp_left_q <= '0;
            serial_out_pin <= 1'b1;
        end else begin
            if (zero_bit_start && sir_lp) lp_left_q <= LP_PULSE_PERIODS;
            else if (lowpower_ir_ref_clk && lp_pulse) lp_left_q <= lp_left_q - 2'h1;
            serial_out_pin <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loopback, ir decoder, receiver
    rx_state_e rx_st_q;
    logic [3:0] rx_sub_q;
    logic [3:0] rx_idx_q;
    logic [7:0] rx_sh_q;
    logic [3:0] dec_cnt_q;

    // loopback inverts the encoded pulse as a transceiver would
    wire loop_src = sir_en ? !serial_out_pin : serial_out_pin;
    wire line_in = loopback_enable ? loop_src : serial_in_pin; // see [RQ20]
    // a low pulse holds the decoded zero for one bit period
    wire rx_line = sir_en ? (line_in && dec_cnt_q == '0) : line_in; // see [RQ4]
    wire rx_sample = oversample_ref_clk && (rx_sub_q == TICK_LAST);
    assign rx_push = (rx_st_q == RX_STOP) && rx_sample;
    assign rx_new = '{oe: rx_full, be: !rx_line && (rx_sh_q == '0), pe: 1'b0, fe: !rx_line, data: rx_sh_q};

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            dec_cnt_q <= '0;
        end else if (sir_en && !line_in) begin
            dec_cnt_q <= TICK_LAST;
        end else if (oversample_ref_clk && dec_cnt_q != '0) begin
            dec_cnt_q <= dec_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_st_q <= RX_IDLE;
            rx_sub_q <= '0;
            rx_idx_q <= '0;
            rx_sh_q <= '0;
        end else begin
            if (oversample_ref_clk) rx_sub_q <= rx_sub_q + 4'h1;
            case (rx_st_q)
                RX_IDLE: begin
                    rx_sub_q <= '0;
                    if (rx_go && !rx_line) rx_st_q <= RX_START;
                end
                RX_START: begin
                    if (oversample_ref_clk && rx_sub_q == START_MID) begin
                        rx_sub_q <= '0;
                        rx_idx_q <= '0;
                        rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin // see [RQ22]
                        rx_sh_q <= {rx_line, rx_sh_q[7:1]};
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == DATA_LAST) rx_st_q <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive timeout
    logic [3:0] rt_sub_q;
    logic [5:0] rt_cnt_q;
    logic rt_done_q;
    wire rt_restart = rx_empty || rx_ins || rx_pop;
    wire rt_bit = oversample_ref_clk && (rt_sub_q == TICK_LAST);
    wire rt_event = !rt_restart && rt_bit && !rt_done_q && (rt_cnt_q == RT_LAST); // see [RQ23]

    always_ff @(posedge mclk) begin
        if (!rst_b || rt_restart) begin
            rt_sub_q <= '0;
            rt_cnt_q <= '0;
            rt_done_q <= 1'b0;
        end else begin
            if (oversample_ref_clk) rt_sub_q <= rt_sub_q + 4'h1;
            if (rt_bit && !rt_done_q) rt_cnt_q <= rt_cnt_q + 6'h1;
            if (rt_event) rt_done_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status
    logic [2:0] rx_sel, tx_sel;
    logic [CW-1:0] rx_lvl, tx_lvl;
    logic rx_cond_q, tx_cond_q;
    assign rx_sel = ifls_q[IFLS_RX_LSB +: 3];
    assign tx_sel = ifls_q[IFLS_TX_LSB +: 3];

    function automatic logic [CW-1:0] level_of(input logic [2:0] sel);
        logic [CW+2:0] d8;
        d8 = (CW + 3)'(DEPTH);
        case (sel)
            3'h0: level_of = CW'(d8 >> 3);
            3'h1: level_of = CW'(d8 >> 2);
            3'h3: level_of = CW'((d8 >> 1) + (d8 >> 2));
            3'h4: level_of = CW'(d8 - (d8 >> 3));
            default: level_of = CW'(d8 >> 1);
        endcase
    endfunction : level_of

    assign rx_lvl = level_of(rx_sel); // see [RQ11]
    assign tx_lvl = level_of(tx_sel);
    wire rx_cond = queue_enable ? (rx_cnt_q >= rx_lvl) : !rx_empty; // see [RQ16] [RQ17]
    wire tx_cond = queue_enable ? (tx_cnt_q <= tx_lvl) : tx_empty; // see [RQ18] [RQ19]
    wire fe_ev = rx_ins && rx_new.fe;
    wire be_ev = rx_ins && rx_new.be;

    always_comb begin
        ris_d = (ris_q & ~clr); // see [RQ15]
        ris_d[IRQ_RX] = ris_q[IRQ_RX] && rx_cond && !clr[IRQ_RX];
        ris_d[IRQ_TX] = ris_q[IRQ_TX] && tx_cond && !clr[IRQ_TX];
        // new events win over a clear in the same cycle
        if (rx_cond && !rx_cond_q) ris_d[IRQ_RX] = 1'b1;
        if (tx_cond && !tx_cond_q) ris_d[IRQ_TX] = 1'b1;
        if (rt_event) ris_d[IRQ_RT] = 1'b1;
        if (fe_ev) ris_d[IRQ_FE] = 1'b1;
        if (be_ev) ris_d[IRQ_BE] = 1'b1;
        if (rx_ovr) ris_d[IRQ_OE] = 1'b1;
        ris_d[3:0] = '0;
        ris_d[IRQ_PE] = 1'b0;
    end

    always_comb begin
        rsr_d = wr_rsr ? '0 : rsr_q;
        if (rx_pop) rsr_d[2:0] = {rx_head.be, rx_head.pe, rx_head.fe};
        if (rx_ovr) rsr_d[3] = 1'b1; // see [RQ10]
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ris_q <= '0;
            rsr_q <= '0;
            rx_cond_q <= 1'b0;
            tx_cond_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            ris_q <= ris_d; // see [RQ14]
            rsr_q <= rsr_d;
            rx_cond_q <= rx_cond;
            tx_cond_q <= tx_cond;
            irq <= |(ris_q & im_q); // see [RQ12] [RQ13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe
    wire tx_busy = !tx_empty || (tx_st_q != TX_IDLE);
    wire [7:0] flag_word = 8'((tx_busy << FLAG_BUSY) | (rx_empty << FLAG_RX_QUEUE_EMPTY) | (tx_full << FLAG_TX_QUEUE_FULL)
        | (rx_full << FLAG_RX_QUEUE_FULL) | (tx_empty << FLAG_TX_QUEUE_EMPTY)); // see [RQ10]

    always_comb begin
        rd_word = '0;
        if (addr == OFF_DATA) rd_word = rx_empty ? '0 : DATA_W'(rx_head);
        else if (addr == OFF_RSR) rd_word = DATA_W'(rsr_q);
        else if (addr == OFF_FLAG) rd_word = DATA_W'(flag_word);
        else if (addr == OFF_ILPR) rd_word = DATA_W'(ilpr_q);
        else if (addr == OFF_IBRD) rd_word = DATA_W'(ibrd_q);
        else if (addr == OFF_LCRH) rd_word = DATA_W'(lcrh_q);
        else if (addr == OFF_CTL) rd_word = DATA_W'(ctl_q);
        else if (addr == OFF_IFLS) rd_word = DATA_W'(ifls_q);
        else if (addr == OFF_IM) rd_word = DATA_W'(im_q);
        else if (addr == OFF_RIS) rd_word = DATA_W'(ris_q);
        else if (addr == OFF_MIS) rd_word = DATA_W'(ris_q & im_q); // see [RQ24]
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) rd_data <= '0;
        else rd_data <= rd_en ? rd_word : '0;
    end

    // no turnaround gap is timed here; software owns it
    // see [RQ5] [RQ6]
endmodule : uart_sir_fifo_irq
`default_nettype wire

// ### logic/uart_pkg.sv
`default_nettype none
package uart_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_RSR = 12'h004;
    localparam logic [11:0] OFF_FLAG = 12'h018;
    localparam logic [11:0] OFF_ILPR = 12'h020;
    localparam logic [11:0] OFF_IBRD = 12'h024;
    localparam logic [11:0] OFF_LCRH = 12'h02c;
    localparam logic [11:0] OFF_CTL = 12'h030;
    localparam logic [11:0] OFF_IFLS = 12'h034;
    localparam logic [11:0] OFF_IM = 12'h038;
    localparam logic [11:0] OFF_RIS = 12'h03c;
    localparam logic [11:0] OFF_MIS = 12'h040;
    localparam logic [11:0] OFF_ICR = 12'h044;
    // control register fields
    localparam int CTL_W = 10;
    localparam logic [9:0] CTL_RST = 10'h300;
    localparam int CTL_EN = 0;
    localparam int CTL_SIR = 1;
    localparam int CTL_SIRLP = 2;
    localparam int CTL_LBE = 7;
    localparam int CTL_TXE = 8;
    localparam int CTL_RXE = 9;
    localparam int LCRH_FEN = 4;
    // trigger level select fields
    localparam logic [5:0] IFLS_RST = 6'h12;
    localparam int IFLS_TX_LSB = 0;
    localparam int IFLS_RX_LSB = 3;
    // interrupt bit positions
    localparam int IRQ_W = 11;
    localparam int IRQ_RX = 4;
    localparam int IRQ_TX = 5;
    localparam int IRQ_RT = 6;
    localparam int IRQ_FE = 7;
    localparam int IRQ_PE = 8;
    localparam int IRQ_BE = 9;
    localparam int IRQ_OE = 10;
    // flag register bit positions
    localparam int FLAG_BUSY = 3;
    localparam int FLAG_RX_QUEUE_EMPTY = 4;
    localparam int FLAG_TX_QUEUE_FULL = 5;
    localparam int FLAG_RX_QUEUE_FULL = 6;
    localparam int FLAG_TX_QUEUE_EMPTY = 7;
    // timing in oversample ticks, low-power reference periods and bit counts
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] START_MID = 4'h7;
    localparam logic [3:0] SIR_NORM_TICKS = 4'h3;
    localparam logic [1:0] LP_PULSE_PERIODS = 2'h3;
    localparam logic [3:0] DATA_LAST = 4'h7;

    typedef struct packed {
        logic oe;
        logic be;
        logic pe;
        logic fe;
        logic [7:0] data;
    } rx_entry_s;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : uart_pkg
`default_nettype wire

// ### verification/uart_sir_fifo_irq_asserts.sv
`default_nettype none
module uart_sir_fifo_irq_asserts #(
    parameter int DEPTH = 16,
    parameter int TIMEOUT_BITS = 32
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [uart_pkg::ADDR_W-1:0] addr,
    input wire logic [uart_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [uart_pkg::DATA_W-1:0] rd_data,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // shadows of mask, control and divisor, built from bus writes only
    logic [IRQ_W-1:0] mask_q;
    logic [CTL_W-1:0] ctl_q;
    logic [15:0] ibrd_q;
    logic [15:0] run_q;
    logic pin_q;
    logic ok_q;
    wire logic ir_norm = ctl_q[CTL_SIR] && !ctl_q[CTL_SIRLP];
    wire logic pin_rise = serial_out_pin && !pin_q;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mask_q <= '0;
            ctl_q <= CTL_RST;
            ibrd_q <= '0;
            run_q <= '0;
            pin_q <= 1'b1;
            ok_q <= 1'b0;
        end else begin
            if (wr_en && addr == OFF_IM) mask_q <= wr_data[IRQ_W-1:0];
            if (wr_en && addr == OFF_CTL) ctl_q <= wr_data[CTL_W-1:0];
            if (wr_en && addr == OFF_IBRD) ibrd_q <= wr_data[15:0];
            pin_q <= serial_out_pin;
            run_q <= pin_rise ? 16'h1 : run_q + 16'h1;
            // a pulse counts only if it began in normal ir mode
            if (pin_rise) ok_q <= ir_norm;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(logic [11:0] a);
        rd_en && addr == a;
    endsequence
    property p_rd_quiet; !rd_en |=> rd_data == '0; endproperty
    property p_unmapped; rd_en && addr > OFF_ICR |=> rd_data == '0; endproperty
    property p_data_width; s_rd(OFF_DATA) |=> rd_data[31:12] == '0; endproperty
    property p_rsr_width; s_rd(OFF_RSR) |=> rd_data[31:4] == '0; endproperty
    property p_flag_excl;
        s_rd(OFF_FLAG) |=> !(rd_data[FLAG_RX_QUEUE_EMPTY] && rd_data[FLAG_RX_QUEUE_FULL]) && !(rd_data[FLAG_TX_QUEUE_EMPTY] && rd_data[FLAG_TX_QUEUE_FULL]);
    endproperty
    property p_mis_masked; s_rd(OFF_MIS) |=> (rd_data[IRQ_W-1:0] & ~mask_q) == '0; endproperty
    property p_irq_follows; s_rd(OFF_MIS) |=> irq == (rd_data != '0); endproperty
    property p_ir_pulse; ok_q && ir_norm && $fell(serial_out_pin) |-> run_q == ibrd_q * 16'h3; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero when idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_data_width: assert property (p_data_width) else $error("data read wider than 12 bits");
    a_rsr_width: assert property (p_rsr_width) else $error("status read wider than 4 bits");
    a_flag_excl: assert property (p_flag_excl) else $error("empty and full flags both set");
    a_mis_masked: assert property (p_mis_masked) else $error("masked status shows masked bit");
    a_irq_follows: assert property (p_irq_follows) else $error("irq differs from masked status");
    a_ir_pulse: assert property (p_ir_pulse) else $error("ir pulse not 3 ticks");
endmodule : uart_sir_fifo_irq_asserts
bind uart_sir_fifo_irq uart_sir_fifo_irq_asserts #(
    .DEPTH(DEPTH),
    .TIMEOUT_BITS(TIMEOUT_BITS)
) i_uart_sir_fifo_irq_asserts (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq)
);
`default_nettype wire

// ### verification/ir_peer.sv
`default_nettype none
module ir_peer #(
    parameter int BIT_CYC = 32,
    parameter int PULSE_CYC = 6
) (
    input wire logic mclk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle high: the receive pin is pulled up while nobody sends
    initial line = 1'b1;
    // 8n1 lsb first; in ir mode a zero is only a short low pulse
    task automatic send(input logic [7:0] b, input logic ir);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            line <= f[i];
            repeat (PULSE_CYC) @(posedge mclk);
            if (ir) begin
                line <= 1'b1;
            end
            repeat (BIT_CYC - PULSE_CYC - 1) @(posedge mclk);
        end
    endtask : send
endmodule : ir_peer
`default_nettype wire

// ### verification/tb_uart_sir_fifo_irq.sv
`default_nettype none
module tb_uart_sir_fifo_irq;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_pkg::*;
    // ir turnaround gap shortened; the hardware never times it, only the order matters
    localparam int GAP = 2000;
    localparam logic [31:0] ALL = 32'hffffffff;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic serial_in_pin;
    logic serial_out_pin;
    logic irq;
    int errors = 0;
    int checks = 0;
    int n;
    uart_sir_fifo_irq #(.DEPTH(16), .TIMEOUT_BITS(32)) i_uart_sir_fifo_irq (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq)
    );
    ir_peer #(.BIT_CYC(32), .PULSE_CYC(6)) i_ir_peer (.mclk(mclk), .line(serial_in_pin));
    initial begin
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    // each access starts on an edge so strobes never change twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic cmp(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", s, exp, seen);
        end
    endtask : cmp
    task automatic chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        cmp($sformatf("reg %h", a), d & m, e);
    endtask : chk
    task automatic idle(input int c);
        repeat (c) @(posedge mclk);
    endtask : idle
    // counts high cycles on the output over one character time
    task automatic hi_count(output int k);
        k = 0;
        repeat (400) begin
            @(posedge mclk);
            #1 if (serial_out_pin === 1'b1) k++;
        end
    endtask : hi_count
    task automatic done(input string s);
        $display("test %s finished, errors so far %0d", s, errors);
    endtask : done
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        $display("unexpected run length: expected end seen hang");
        results();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        chk(OFF_CTL, ALL, 32'h300);
        chk(OFF_IFLS, ALL, 32'h12);
        chk(OFF_FLAG, 32'hf0, 32'h90);
        chk(OFF_RIS, ALL, 32'h20);
        chk(OFF_MIS, ALL, 32'h0);
        chk(12'h100, ALL, 32'h0);
        done("reset");
        wr(OFF_IM, 32'h20);
        chk(OFF_MIS, ALL, 32'h20);
        cmp("irq", {31'h0, irq}, 32'h1);
        wr(OFF_ICR, 32'h0);
        chk(OFF_RIS, ALL, 32'h20);
        wr(OFF_ICR, 32'h20);
        chk(OFF_RIS, ALL, 32'h0);
        cmp("irq", {31'h0, irq}, 32'h0);
        done("mask");
        wr(OFF_IM, 32'h7f0);
        wr(OFF_IBRD, 32'h2);
        wr(OFF_CTL, 32'h381);
        wr(OFF_DATA, 32'ha5);
        idle(400);
        chk(OFF_RIS, 32'h30, 32'h30);
        wr(OFF_DATA, 32'h5a);
        idle(400);
        chk(OFF_RSR, ALL, 32'h8);
        chk(OFF_MIS, 32'h400, 32'h400);
        chk(OFF_DATA, 32'hff, 32'ha5);
        chk(OFF_RIS, 32'h10, 32'h0);
        wr(OFF_RSR, 32'h0);
        chk(OFF_RSR, ALL, 32'h0);
        wr(OFF_ICR, 32'h7ff);
        done("loopback");
        wr(OFF_CTL, 32'h303);
        wr(OFF_DATA, 32'h0);
        hi_count(n);
        cmp("ir pulse cycles", n, 32'd54);
        wr(OFF_ILPR, 32'h4);
        wr(OFF_CTL, 32'h307);
        wr(OFF_DATA, 32'h0);
        hi_count(n);
        cmp("lowpower pulse cycles in range", n >= 81 && n <= 108, 32'h1);
        done("ir transmit");
        wr(OFF_CTL, 32'h303);
        idle(GAP);
        i_ir_peer.send(8'h3c, 1'b1);
        idle(100);
        chk(OFF_DATA, 32'hfff, 32'h3c);
        wr(OFF_CTL, 32'h301);
        i_ir_peer.send(8'hc3, 1'b0);
        idle(100);
        chk(OFF_DATA, 32'hfff, 32'hc3);
        wr(OFF_ICR, 32'h7ff);
        done("receive");
        wr(OFF_LCRH, 32'h10);
        wr(OFF_IFLS, 32'h0a);
        wr(OFF_CTL, 32'h381);
        wr(OFF_ICR, 32'h7ff);
        for (int i = 1; i < 5; i++) wr(OFF_DATA, i);
        idle(1040);
        chk(OFF_RIS, 32'h10, 32'h0);
        idle(280);
        chk(OFF_RIS, 32'h10, 32'h10);
        chk(OFF_RSR, ALL, 32'h0);
        chk(OFF_DATA, 32'hfff, 32'h1);
        chk(OFF_RIS, 32'h10, 32'h0);
        idle(1100);
        chk(OFF_RIS, 32'h40, 32'h40);
        wr(OFF_ICR, 32'h7ff);
        done("queued receive");
        wr(OFF_CTL, 32'h300);
        for (int i = 0; i < 15; i++) wr(OFF_DATA, i);
        chk(OFF_FLAG, 32'h20, 32'h0);
        wr(OFF_DATA, 32'hee);
        chk(OFF_FLAG, 32'ha0, 32'h20);
        chk(OFF_RIS, 32'h20, 32'h0);
        wr(OFF_CTL, 32'h301);
        idle(3300);
        chk(OFF_RIS, 32'h20, 32'h20);
        chk(OFF_FLAG, 32'h80, 32'h0);
        wr(OFF_CTL, 32'h300);
        for (int i = 0; i < 9; i++) wr(OFF_DATA, i);
        chk(OFF_RIS, 32'h20, 32'h0);
        done("queued transmit");
        results();
    end
endmodule : tb_uart_sir_fifo_irq
`default_nettype wire
